// ---- core/estop_trip_terminal.sv ----
// Emergency-stop path, trip latches, terminal function assignment and register slave.
`timescale 1ns/1ps
module estop_trip_terminal
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] terminal_in,
  input wire logic estop_enable_switch,
  input wire logic [13:0] thermistor_ohms,
  input wire logic operator_clear,
  input wire logic [50:0] status_functions,
  input wire logic [3:0] drive_alarm_code,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic gate_block,
  output logic fault_reset,
  output logic [4:0] oc_out,
  output logic relay_out,
  output logic [7:0] trip_code,
  output logic irq
);

  estop_trip_pkg::state_s s;
  estop_trip_pkg::state_s next_s;

  function automatic logic reset_held_elsewhere(input logic [7:0][7:0] f);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < estop_trip_pkg::NUM_IN; i++)
    begin
      if (i != estop_trip_pkg::TERM_RESET_IDX && f[i] == estop_trip_pkg::FUNC_FAULT_RESET)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : reset_held_elsewhere

  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a >= base) && (a < base + 8'(4 * n)) && (a[1:0] == 2'b00);
  endfunction : in_window

  logic en;
  logic estop_now;
  logic reset_term1;
  logic reset_any;
  logic therm_hit;
  logic [50:0] funcs;
  logic [3:0] alarm_code;
  logic [2:0] events;
  logic req;
  logic take;
  logic refused;
  logic [31:0] rd;
  logic [2:0] in_idx;
  logic [2:0] out_idx;

  // The switch is synchronised and reads off after reset, so the stop path starts disabled.
  assign en = s.sw_sync;
  // Terminal 3 reads open for a missing wire or a cut cable too, so all of them trip.
  assign estop_now = en && !s.term_sync[estop_trip_pkg::TERM_ESTOP_IDX];
  assign reset_term1 = en && s.term_sync[estop_trip_pkg::TERM_RESET_IDX];
  assign therm_hit = thermistor_ohms >= s.threshold;
  // Every access gets one wait state, so read data always come from a register.
  assign req = read || write;
  assign take = req && s.served;
  assign waitrequest = req && !s.served;
  assign in_idx = 3'((address - estop_trip_pkg::ADDR_IN_FUNC) >> 2);
  assign out_idx = 3'((address - estop_trip_pkg::ADDR_OUT_FUNC) >> 2);

  always_comb
  begin
    reset_any = reset_term1;
    for (int i = 0; i < estop_trip_pkg::NUM_IN; i++)
    begin
      if (s.in_func[i] == estop_trip_pkg::FUNC_FAULT_RESET && s.term_sync[i])
      begin
        reset_any = 1'b1;
      end
    end
    funcs = status_functions;
    funcs[estop_trip_pkg::OUT_FUNC_ALARM] = status_functions[estop_trip_pkg::OUT_FUNC_ALARM]
      || s.estop_trip || s.thermal_trip;
    if (s.estop_trip)
    begin
      alarm_code = estop_trip_pkg::ALARM_CODE_ESTOP;
    end
    else if (s.thermal_trip)
    begin
      alarm_code = estop_trip_pkg::ALARM_CODE_THERMAL;
    end
    else
    begin
      alarm_code = drive_alarm_code;
    end
  end

  always_comb
  begin
    rd = 32'h0000_0000;
    case (address)
      estop_trip_pkg::ADDR_CTRL: rd[1:0] = s.ctrl;
      estop_trip_pkg::ADDR_STATUS: rd = {16'h0000, trip_code, 3'h0, s.gate_block, estop_now, en,
        s.thermal_trip, s.estop_trip};
      estop_trip_pkg::ADDR_IRQ_STATUS: rd[2:0] = s.irq_status;
      estop_trip_pkg::ADDR_IRQ_MASK: rd[2:0] = s.irq_mask;
      estop_trip_pkg::ADDR_THRESH: rd[13:0] = s.threshold;
      estop_trip_pkg::ADDR_RELAY_FUNC: rd[5:0] = s.relay_func;
      estop_trip_pkg::ADDR_LEVELS: rd[13:0] = {s.relay_out, s.oc_out, s.term_sync};
      default:
      begin
        if (in_window(address, estop_trip_pkg::ADDR_IN_FUNC, estop_trip_pkg::NUM_IN))
        begin
          rd[7:0] = s.in_func[in_idx];
        end
        else if (in_window(address, estop_trip_pkg::ADDR_OUT_FUNC, estop_trip_pkg::NUM_OC))
        begin
          rd[5:0] = s.out_func[out_idx];
        end
      end
    endcase
  end

  always_comb
  begin
    next_s = s;
    refused = 1'b0;
    next_s.term_meta = terminal_in;
    next_s.term_sync = s.term_meta;
    next_s.sw_meta = estop_enable_switch;
    next_s.sw_sync = s.sw_meta;
    next_s.en_prev = en;
    next_s.served = req && !s.served;
    if (req && !s.served)
    begin
      next_s.readdata = rd;
    end
    if (take && write)
    begin
      if (address == estop_trip_pkg::ADDR_CTRL)
      begin
        next_s.ctrl = writedata[1:0];
      end
      else if (address == estop_trip_pkg::ADDR_IRQ_MASK)
      begin
        next_s.irq_mask = writedata[2:0];
      end
      else if (address == estop_trip_pkg::ADDR_THRESH)
      begin
        if (writedata[31:0] <= 32'(estop_trip_pkg::THRESH_MAX))
        begin
          next_s.threshold = writedata[13:0];
        end
        else
        begin
          refused = 1'b1;
        end
      end
      else if (address == estop_trip_pkg::ADDR_RELAY_FUNC)
      begin
        if (writedata < 32'(estop_trip_pkg::NUM_RELAY_FUNCS))
        begin
          next_s.relay_func = writedata[5:0];
        end
        else
        begin
          refused = 1'b1;
        end
      end
      else if (in_window(address, estop_trip_pkg::ADDR_IN_FUNC, estop_trip_pkg::NUM_IN))
      begin
        // The stop function is placed only by the switch, never by software.
        if ((en && (in_idx == 3'(estop_trip_pkg::TERM_RESET_IDX)
            || in_idx == 3'(estop_trip_pkg::TERM_ESTOP_IDX)))
            || writedata[7:0] == estop_trip_pkg::FUNC_ESTOP)
        begin
          refused = 1'b1;
        end
        else
        begin
          next_s.in_func[in_idx] = writedata[7:0];
        end
      end
      else if (in_window(address, estop_trip_pkg::ADDR_OUT_FUNC, estop_trip_pkg::NUM_OC))
      begin
        if (writedata < 32'(estop_trip_pkg::NUM_OUT_FUNCS))
        begin
          next_s.out_func[out_idx] = writedata[5:0];
        end
        else
        begin
          refused = 1'b1;
        end
      end
    end
    if (en && !s.en_prev)
    begin
      for (int i = 0; i < estop_trip_pkg::NUM_IN; i++)
      begin
        if (next_s.in_func[i] == estop_trip_pkg::FUNC_FAULT_RESET)
        begin
          next_s.in_func[i] = estop_trip_pkg::FUNC_NONE;
        end
      end
      next_s.in_func[estop_trip_pkg::TERM_RESET_IDX] = estop_trip_pkg::FUNC_FAULT_RESET;
      next_s.in_func[estop_trip_pkg::TERM_ESTOP_IDX] = estop_trip_pkg::FUNC_ESTOP;
    end
    else if (!en && s.en_prev)
    begin
      // Terminal 1 keeps the reset function; terminal 3 is left with nothing assigned.
      next_s.in_func[estop_trip_pkg::TERM_ESTOP_IDX] = estop_trip_pkg::FUNC_NONE;
    end
    // Setting wins over clearing, so a stop that is still open keeps the trip in place.
    if (estop_now)
    begin
      next_s.estop_trip = 1'b1;
    end
    else if (reset_term1 || !en)
    begin
      next_s.estop_trip = 1'b0;
    end
    if (therm_hit)
    begin
      next_s.thermal_trip = 1'b1;
    end
    else if (reset_any || (operator_clear && !s.estop_trip))
    begin
      next_s.thermal_trip = 1'b0;
    end
    next_s.gate_block = estop_now || next_s.estop_trip || next_s.thermal_trip;
    for (int k = 0; k < estop_trip_pkg::NUM_OC; k++)
    begin
      next_s.oc_out[k] = funcs[s.out_func[k]];
    end
    if (s.ctrl[estop_trip_pkg::CTRL_ALARM_EN])
    begin
      next_s.oc_out[2:0] = alarm_code[2:0];
      if (s.ctrl[estop_trip_pkg::CTRL_ALARM_WIDE])
      begin
        next_s.oc_out[3] = alarm_code[3];
      end
    end
    next_s.relay_out = funcs[s.relay_func];
    events = 3'b000;
    events[estop_trip_pkg::IRQ_ESTOP] = next_s.estop_trip && !s.estop_trip;
    events[estop_trip_pkg::IRQ_THERMAL] = next_s.thermal_trip && !s.thermal_trip;
    events[estop_trip_pkg::IRQ_REFUSED] = refused;
    // Only bits that the read returned are cleared, so a fresh event is never lost.
    next_s.irq_status = s.irq_status | events;
    if (take && read && address == estop_trip_pkg::ADDR_IRQ_STATUS)
    begin
      next_s.irq_status = (s.irq_status & ~s.readdata[2:0]) | events;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.in_func <= {8{estop_trip_pkg::FUNC_NONE}};
      s.in_func[estop_trip_pkg::TERM_RESET_IDX] <= estop_trip_pkg::FUNC_FAULT_RESET;
      s.in_func[estop_trip_pkg::TERM_ESTOP_IDX] <= estop_trip_pkg::FUNC_JOG;
      s.out_func <= {6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
      s.relay_func <= estop_trip_pkg::OUT_FUNC_ALARM;
      s.threshold <= estop_trip_pkg::THRESH_RESET;
      s.term_sync <= 8'hff;
      s.term_meta <= 8'hff;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign readdata = s.readdata;
  assign gate_block = s.gate_block;
  assign fault_reset = reset_any;
  assign oc_out = s.oc_out;
  assign relay_out = s.relay_out;
  // Stop outranks thermal, so the code shown is the cause that must be cleared first.
  assign trip_code = s.estop_trip ? estop_trip_pkg::TRIP_CODE_ESTOP :
    (s.thermal_trip ? estop_trip_pkg::TRIP_CODE_THERMAL : 8'h00);
  assign irq = |(s.irq_status & s.irq_mask);

  // The checks watch registered state, so each lines up with the edge that sets it.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_estop_sets_trip: assert property (estop_now |=> s.estop_trip)
    else $error("stop input did not set the trip");
  a_trip_blocks_gates: assert property (s.estop_trip |-> s.gate_block)
    else $error("gates not blocked during stop trip");
  a_trip_stays_latched: assert property (s.estop_trip && !estop_now && !reset_term1 && en
    |=> s.estop_trip)
    else $error("stop trip released without fault reset");
  a_operator_clear_ignored: assert property (s.estop_trip && operator_clear && !reset_any
    && s.sw_sync ##1 1'b1 |-> s.estop_trip && $past(s.thermal_trip) <= s.thermal_trip)
    else $error("operator clear acted during stop trip");
  a_terminals_dedicated: assert property (s.sw_sync && s.en_prev |->
    s.in_func[0] == estop_trip_pkg::FUNC_FAULT_RESET
    && s.in_func[2] == estop_trip_pkg::FUNC_ESTOP)
    else $error("dedicated terminals hold another function");
  a_reset_dedup: assert property (s.sw_sync && !s.en_prev |=> !reset_held_elsewhere(s.in_func))
    else $error("fault reset left on another terminal");
  a_thermal_trip: assert property (therm_hit |=> s.thermal_trip && s.gate_block)
    else $error("thermistor threshold did not trip");
  a_alarm_code_out: assert property ($past(s.estop_trip) && $past(s.ctrl[0]) |->
    s.oc_out[2:0] == estop_trip_pkg::ALARM_CODE_ESTOP[2:0])
    else $error("alarm code missing on outputs");
  a_refused_write: assert property (take && write && en && s.en_prev
    && address == estop_trip_pkg::ADDR_IN_FUNC |=> s.irq_status[2]
    && s.in_func[0] == estop_trip_pkg::FUNC_FAULT_RESET)
    else $error("write to dedicated terminal not refused");
  a_enable_off: assert property (!s.sw_sync |-> !estop_now && !reset_term1)
    else $error("stop path active with switch off");

endmodule : estop_trip_terminal

// ---- inc/estop_trip_pkg.sv ----
// Constants, register map and state layout for the emergency-stop and trip terminal block.
package estop_trip_pkg;
  localparam int NUM_IN = 8;
  localparam int NUM_OC = 5;
  localparam int NUM_OUT_FUNCS = 51;
  localparam int NUM_RELAY_FUNCS = 43;
  localparam logic [13:0] THRESH_MAX = 14'd9999;
  localparam logic [13:0] THRESH_RESET = 14'd3000;
  localparam logic [7:0] FUNC_FAULT_RESET = 8'h12;
  localparam logic [7:0] FUNC_ESTOP = 8'h40;
  localparam logic [7:0] FUNC_JOG = 8'h06;
  localparam logic [7:0] FUNC_NONE = 8'hff;
  localparam int TERM_RESET_IDX = 0;
  localparam int TERM_ESTOP_IDX = 2;
  localparam logic [5:0] OUT_FUNC_ALARM = 6'h05;
  localparam logic [7:0] TRIP_CODE_ESTOP = 8'h25;
  localparam logic [7:0] TRIP_CODE_THERMAL = 8'h01;
  localparam logic [3:0] ALARM_CODE_ESTOP = 4'h1;
  localparam logic [3:0] ALARM_CODE_THERMAL = 4'h2;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_THRESH = 8'h10;
  localparam logic [7:0] ADDR_RELAY_FUNC = 8'h14;
  localparam logic [7:0] ADDR_LEVELS = 8'h18;
  localparam logic [7:0] ADDR_IN_FUNC = 8'h20;
  localparam logic [7:0] ADDR_OUT_FUNC = 8'h40;
  localparam int CTRL_ALARM_EN = 0;
  localparam int CTRL_ALARM_WIDE = 1;
  localparam int IRQ_ESTOP = 0;
  localparam int IRQ_THERMAL = 1;
  localparam int IRQ_REFUSED = 2;

  typedef struct packed {
    logic [7:0] term_meta;
    logic [7:0] term_sync;
    logic sw_meta;
    logic sw_sync;
    logic en_prev;
    logic [7:0][7:0] in_func;
    logic [4:0][5:0] out_func;
    logic [5:0] relay_func;
    logic [13:0] threshold;
    logic [1:0] ctrl;
    logic estop_trip;
    logic thermal_trip;
    logic gate_block;
    logic [4:0] oc_out;
    logic relay_out;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic served;
    logic [31:0] readdata;
  } state_s;
endpackage : estop_trip_pkg

// ---- sim/emergency_stop_trip_terminal_logic_test.sv ----
// Self-checking testbench for the emergency-stop and trip terminal block.
`timescale 1ns/1ps
module emergency_stop_trip_terminal_logic_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stop_open = 1'b0;
  logic reset_pressed = 1'b0;
  logic switch_on = 1'b0;
  logic [7:0] terminal_in;
  logic estop_enable_switch;
  logic [13:0] thermistor_ohms = 14'h0000;
  logic operator_clear = 1'b0;
  logic [50:0] status_functions = '0;
  logic [3:0] drive_alarm_code = 4'h0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, gate_block, fault_reset, relay_out, irq;
  logic [4:0] oc_out;
  logic [7:0] trip_code;
  logic [31:0] rdata;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;

  estop_contacts contacts_u (.stop_open(stop_open), .reset_pressed(reset_pressed),
    .switch_on(switch_on), .terminal_in(terminal_in), .estop_enable_switch(estop_enable_switch));

  estop_trip_terminal dut_u (.clk(clk), .rst(rst), .terminal_in(terminal_in),
    .estop_enable_switch(estop_enable_switch), .thermistor_ohms(thermistor_ohms),
    .operator_clear(operator_clear), .status_functions(status_functions),
    .drive_alarm_code(drive_alarm_code), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .gate_block(gate_block), .fault_reset(fault_reset), .oc_out(oc_out),
    .relay_out(relay_out), .trip_code(trip_code), .irq(irq));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    if (failures == 0 && n_tests > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // The whole run takes well under a thousand cycles, so a hang is cut short here.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      results();
    end
  end

  task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_out

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks

  // A spare edge before each request keeps a strobe from being lowered and raised at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    write <= 1'b0;
  endtask : wr

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    rdata = readdata;
    read <= 1'b0;
    n_tests = n_tests + 1;
    if (rdata !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, rdata, exp);
    end
  endtask : expect_reg

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    ticks(4);
    expect_reg(estop_trip_pkg::ADDR_STATUS, 32'h0);
    expect_reg(estop_trip_pkg::ADDR_IN_FUNC + 8'h08, 32'h06);
    expect_reg(estop_trip_pkg::ADDR_THRESH, 32'd3000);
    expect_reg(8'hfc, 32'h0);
    wr(estop_trip_pkg::ADDR_IN_FUNC + 8'h04, 32'h12);
    switch_on <= 1'b1;
    ticks(6);
    expect_reg(estop_trip_pkg::ADDR_IN_FUNC + 8'h04, 32'hff);
    expect_reg(estop_trip_pkg::ADDR_IN_FUNC, 32'h12);
    expect_reg(estop_trip_pkg::ADDR_IN_FUNC + 8'h08, 32'h40);
    wr(estop_trip_pkg::ADDR_IN_FUNC + 8'h08, 32'h06);
    expect_reg(estop_trip_pkg::ADDR_IN_FUNC + 8'h08, 32'h40);
    wr(estop_trip_pkg::ADDR_IN_FUNC, 32'h06);
    expect_reg(estop_trip_pkg::ADDR_IN_FUNC, 32'h12);
    wr(estop_trip_pkg::ADDR_IRQ_MASK, 32'h1);
    ticks(2);
    check_out({7'h0, irq}, 8'h00);
    // Opening the stop chain trips the drive and blocks switching.
    stop_open <= 1'b1;
    ticks(8);
    check_out(trip_code, estop_trip_pkg::TRIP_CODE_ESTOP);
    check_out({7'h0, gate_block}, 8'h01);
    check_out({7'h0, irq}, 8'h01);
    expect_reg(estop_trip_pkg::ADDR_STATUS, 32'h251d);
    expect_reg(estop_trip_pkg::ADDR_IRQ_STATUS, 32'h5);
    expect_reg(estop_trip_pkg::ADDR_IRQ_STATUS, 32'h0);
    ticks(2);
    check_out({7'h0, irq}, 8'h00);
    // Closing the chain and a panel clear must leave the trip latched.
    stop_open <= 1'b0;
    operator_clear <= 1'b1;
    ticks(8);
    operator_clear <= 1'b0;
    check_out(trip_code, estop_trip_pkg::TRIP_CODE_ESTOP);
    check_out({7'h0, gate_block}, 8'h01);
    expect_reg(estop_trip_pkg::ADDR_STATUS, 32'h2515);
    wr(estop_trip_pkg::ADDR_CTRL, 32'h1);
    ticks(2);
    check_out({5'h0, oc_out[2:0]}, {5'h0, estop_trip_pkg::ALARM_CODE_ESTOP[2:0]});
    wr(estop_trip_pkg::ADDR_CTRL, 32'h0);
    reset_pressed <= 1'b1;
    ticks(6);
    check_out({7'h0, fault_reset}, 8'h01);
    reset_pressed <= 1'b0;
    ticks(6);
    check_out(trip_code, 8'h00);
    check_out({7'h0, gate_block}, 8'h00);
    // Thermistor threshold at its boundary, then alarm code on the outputs.
    wr(estop_trip_pkg::ADDR_THRESH, 32'd100);
    wr(estop_trip_pkg::ADDR_THRESH, 32'd10000);
    expect_reg(estop_trip_pkg::ADDR_THRESH, 32'd100);
    thermistor_ohms <= 14'd99;
    ticks(6);
    check_out(trip_code, 8'h00);
    thermistor_ohms <= 14'd100;
    ticks(6);
    check_out(trip_code, estop_trip_pkg::TRIP_CODE_THERMAL);
    check_out({7'h0, relay_out}, 8'h01);
    wr(estop_trip_pkg::ADDR_CTRL, 32'h1);
    ticks(4);
    check_out({5'h0, oc_out[2:0]}, {5'h0, estop_trip_pkg::ALARM_CODE_THERMAL[2:0]});
    thermistor_ohms <= 14'd0;
    operator_clear <= 1'b1;
    ticks(2);
    operator_clear <= 1'b0;
    ticks(4);
    check_out(trip_code, 8'h00);
    check_out({7'h0, relay_out}, 8'h00);
    drive_alarm_code <= 4'h9;
    wr(estop_trip_pkg::ADDR_CTRL, 32'h3);
    ticks(4);
    check_out({4'h0, oc_out[3:0]}, 8'h09);
    wr(estop_trip_pkg::ADDR_CTRL, 32'h0);
    wr(estop_trip_pkg::ADDR_OUT_FUNC, 32'd50);
    status_functions[50] <= 1'b1;
    ticks(4);
    check_out({7'h0, oc_out[0]}, 8'h01);
    wr(estop_trip_pkg::ADDR_OUT_FUNC, 32'd51);
    expect_reg(estop_trip_pkg::ADDR_OUT_FUNC, 32'd50);
    wr(estop_trip_pkg::ADDR_RELAY_FUNC, 32'd43);
    expect_reg(estop_trip_pkg::ADDR_RELAY_FUNC, 32'd5);
    results();
  end
endmodule : emergency_stop_trip_terminal_logic_test

// ---- sim/estop_contacts.sv ----
// Model of the external stop contacts, reset push-button and internal enable switch.
`timescale 1ns/1ps
module estop_contacts
(
  input wire logic stop_open,
  input wire logic reset_pressed,
  input wire logic switch_on,
  output logic [7:0] terminal_in,
  output logic estop_enable_switch
);
  // Unwired terminals read as open contacts.
  assign terminal_in[7:3] = 5'h00;
  assign terminal_in[1] = 1'b0;
  // The stop chain is normally closed, so a broken cable reads as an opened contact.
  assign terminal_in[2] = ~stop_open;
  assign terminal_in[0] = reset_pressed;
  assign estop_enable_switch = switch_on;
endmodule : estop_contacts
